// [rtl/lcd_drive_pkg.sv]
// Purpose: Shared constants for the LCD segment drive control block
// Assumes: 4-bit CPU data bus, 12-bit register address, 100 MHz system clock
// Notes:   Register offsets are the CPU data-space addresses
package lcd_drive_pkg;
  // ==========================================================
  // Bus widths
  localparam int ADDR_W = 12; // CPU address width
  localparam int DATA_W = 4; // CPU data width

  // ==========================================================
  // Register offsets
  localparam logic [11:0] BLANK_CTRL_ADDR = 12'h2d0; // Display blank control
  localparam logic [11:0] FORMAT_CTRL_ADDR = 12'h2e8; // Drive format and timer masks
  localparam logic [11:0] DISP_BASE_PAGE0 = 12'h040; // Display memory, page 0
  localparam logic [11:0] DISP_BASE_PAGE2 = 12'h240; // Display memory, page 2
  localparam int DISP_PAGE_RW = 0; // Page number with readable memory
  localparam int DISP_PAGE_WO = 2; // Page number with write-only memory

  // ==========================================================
  // Field positions and reset values
  localparam int BLANK_BIT = 0; // Blank control bit position
  localparam int FORMAT_BIT = 3; // Drive format bit position
  localparam int MASK_LSB = 0; // Timer mask field low bit
  localparam int MASK_W = 3; // Timer mask field width
  localparam logic BLANK_RESET = 1'b1; // Normal display after reset
  localparam logic FORMAT_RESET = 1'b0; // Dynamic drive after reset
  localparam logic [2:0] MASK_RESET = 3'h0; // Timer interrupts masked

  // ==========================================================
  // Panel geometry
  localparam int DISP_WORDS = 48; // Display memory words
  localparam int SEG_COUNT = 48; // Segment terminals
  localparam int COM_COUNT = 4; // Common terminals
  localparam int DC_PAIRS = 24; // Segment pairs with DC option

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 100_000_000; // System clock rate
  localparam int OSC_HZ = 32_768; // Low-speed oscillator rate
  localparam int FRAME_DIV_STD = 1024; // Oscillator ticks per frame
  localparam int FRAME_DIV_THIRD = 768; // Oscillator ticks per frame, three commons
endpackage : lcd_drive_pkg

// [rtl/display_mem_if.sv]
// Purpose: Carrier between drive control and display memory
// Assumes: One access per cycle, write and read never together
// Notes:   Column ports give all segment bits of one common at once
`timescale 1ns/10ps
interface display_mem_if;
  logic wr; // Write strobe
  logic rd; // Read strobe
  logic [5:0] addr; // Word index
  logic [3:0] wdata; // Write data
  logic [3:0] rdata; // Registered read data
  logic [1:0] col_sel; // Common whose bits are wanted
  logic [47:0] col_bits; // Registered bits of selected common
  logic [47:0] com0_bits; // Registered bits of first common

  modport ctrl (output wr, output rd, output addr, output wdata, output col_sel,
                input rdata, input col_bits, input com0_bits);
  modport mem (input wr, input rd, input addr, input wdata, input col_sel,
               output rdata, output col_bits, output com0_bits);
endinterface : display_mem_if

// [rtl/display_memory.sv]
// Purpose: 48 x 4 display memory with CPU port and column read-out
// Assumes: Strobes from the drive control on the same clock
// Notes:   Storage has no reset; contents start undefined
`timescale 1ns/10ps
module display_memory
  import lcd_drive_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  display_mem_if.mem dm
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [DISP_WORDS-1:0][3:0] mem; // Segment bits, word per segment
    logic [3:0] rdata; // CPU read data
    logic [SEG_COUNT-1:0] col; // Selected common column
    logic [SEG_COUNT-1:0] com0; // First common column
  } mem_state_t;

  mem_state_t state; // Registered state
  mem_state_t next_state; // Next state

  // Next-state logic: write, read and column gather
  always_comb begin
    next_state = state;
    // CPU write stores one word
    if (dm.wr && (dm.addr < 6'(DISP_WORDS))) begin
      next_state.mem[dm.addr] = dm.wdata;
    end
    // CPU read captures one word
    if (dm.rd && (dm.addr < 6'(DISP_WORDS))) begin
      next_state.rdata = state.mem[dm.addr];
    end
    // Gather one bit per word for the scan
    for (int i = 0; i < SEG_COUNT; i++) begin
      next_state.col[i] = state.mem[i][dm.col_sel];
      next_state.com0[i] = state.mem[i][0];
    end
  end

  // Register; storage itself keeps its contents through reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state.rdata <= 4'h0;
      state.col <= '0;
      state.com0 <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign dm.rdata = state.rdata;
  assign dm.col_bits = state.col;
  assign dm.com0_bits = state.com0;
endmodule : display_memory

// [rtl/lcd_segment_drive_control.sv]
// Purpose: LCD segment drive control: blanking, drive format, display scan
// Assumes: 100 MHz clock; low-speed oscillator rate derived by accumulator
// Notes:   Bias voltages are generated outside; outputs are logic levels
`timescale 1ns/10ps
module lcd_segment_drive_control
  import lcd_drive_pkg::*;
#(
  parameter int DUTY = 4, // Commons used in dynamic drive: 2, 3 or 4
  parameter int DISPLAY_PAGE = 0, // Display memory page: 0 or 2
  parameter logic [DC_PAIRS-1:0] DC_PAIR_MASK = '0 // Segment pairs as DC outputs
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  output logic [COM_COUNT-1:0] common_terminals,
  output logic [SEG_COUNT-1:0] segment_terminals,
  output logic drive_phase,
  output logic drive_format_select,
  output logic display_blank_ctrl,
  output logic [MASK_W-1:0] timer_int_mask
);
  // ==========================================================
  // Derived constants
  localparam logic [27:0] OSC_STEP = 28'(OSC_HZ); // Accumulator increment
  localparam logic [27:0] OSC_WRAP = 28'(CLK_HZ); // Accumulator modulus
  localparam logic [11:0] DISP_BASE =
    (DISPLAY_PAGE == DISP_PAGE_WO) ? DISP_BASE_PAGE2 : DISP_BASE_PAGE0; // Window base
  localparam logic [11:0] DISP_LAST = DISP_BASE + 12'(DISP_WORDS - 1); // Window end
  localparam logic DISP_READABLE = (DISPLAY_PAGE == DISP_PAGE_RW); // Reads allowed
  localparam logic [9:0] SLOT_STATIC = 10'(FRAME_DIV_STD / COM_COUNT); // Ticks per column
  localparam logic [9:0] SLOT_DYNAMIC =
    10'((DUTY == 3) ? (FRAME_DIV_THIRD / 3) : (FRAME_DIV_STD / DUTY)); // Ticks per common
  localparam logic [1:0] LAST_COM_STATIC = 2'(COM_COUNT - 1); // Last static column
  localparam logic [1:0] LAST_COM_DYNAMIC = 2'(DUTY - 1); // Last dynamic common

  // ==========================================================
  // State
  typedef struct packed {
    logic [27:0] osc_acc; // Fractional oscillator accumulator
    logic [9:0] tick_cnt; // Oscillator ticks in current common slot
    logic [1:0] com_idx; // Common being driven
    logic phase; // Frame polarity for AC drive
    logic blank_n; // One shows image, zero blanks
    logic static_drive; // One static, zero dynamic
    logic [2:0] timer_mask; // Clock timer mask bits, stored only
    logic rd_mem; // Last read went to display memory
    logic [3:0] reg_rdata; // Control register read data
    logic [COM_COUNT-1:0] com_out; // Common terminal levels
    logic [SEG_COUNT-1:0] seg_out; // Segment terminal levels
  } ctrl_state_t;

  ctrl_state_t state; // Registered state
  ctrl_state_t next_state; // Next state

  display_mem_if dm (); // Link to display memory
  logic mem_hit; // Address in display window
  logic [11:0] mem_offset; // Address minus window base
  logic [SEG_COUNT-1:0] seg_next; // Segment levels for next cycle

  // ==========================================================
  // Display memory
  display_memory u_display_memory (
    .clock(clock),
    .rst(rst),
    .dm(dm.mem)
  );

  // Window decode
  always_comb begin
    mem_hit = (addr >= DISP_BASE) && (addr <= DISP_LAST);
    mem_offset = addr - DISP_BASE;
  end

  // Memory strobes straight from the bus
  assign dm.wr = wr && mem_hit;
  assign dm.rd = rd && mem_hit && DISP_READABLE;
  assign dm.addr = mem_offset[5:0];
  assign dm.wdata = wdata;
  // Static drive walks all four columns whatever the duty
  assign dm.col_sel = state.com_idx;

  // ==========================================================
  // Segment output mapping, one segment per memory word
  for (genvar s = 0; s < SEG_COUNT; s++) begin : g_seg
    if (DC_PAIR_MASK[s / 2]) begin : g_dc
      // DC terminal holds the first common bit steadily
      assign seg_next[s] = dm.com0_bits[s];
    end else begin : g_lcd
      // Lit when bit set and display not blanked
      assign seg_next[s] = dm.col_bits[s] && state.blank_n;
    end
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic osc_tick; // One oscillator period has passed
    logic [27:0] acc_sum; // Accumulator plus step
    logic [9:0] slot_len; // Ticks per common in current format
    logic [1:0] last_com; // Last common in current format
    osc_tick = 1'b0;
    acc_sum = state.osc_acc + OSC_STEP;
    slot_len = state.static_drive ? SLOT_STATIC : SLOT_DYNAMIC;
    last_com = state.static_drive ? LAST_COM_STATIC : LAST_COM_DYNAMIC;
    next_state = state;

    // Oscillator rate enable from the system clock
    if (acc_sum >= OSC_WRAP) begin
      next_state.osc_acc = acc_sum - OSC_WRAP;
      osc_tick = 1'b1;
    end else begin
      next_state.osc_acc = acc_sum;
    end

    // Common scan: slot counter, common index, frame polarity
    if (osc_tick) begin
      if (state.tick_cnt >= slot_len - 10'h001) begin
        next_state.tick_cnt = 10'h000;
        if (state.com_idx >= last_com) begin
          // Frame ends: 1024 ticks static, per duty otherwise
          next_state.com_idx = 2'h0;
          next_state.phase = !state.phase;
        end else begin
          next_state.com_idx = state.com_idx + 2'h1;
        end
      end else begin
        next_state.tick_cnt = state.tick_cnt + 10'h001;
      end
    end

    // Common levels
    if (state.static_drive) begin
      // All commons carry one waveform in static drive
      next_state.com_out = {COM_COUNT{1'b1}};
    end else begin
      // One common active at a time
      next_state.com_out = 4'h1 << state.com_idx;
    end

    // Segment levels
    next_state.seg_out = seg_next;

    // Control register writes
    if (wr) begin
      if (addr == BLANK_CTRL_ADDR) begin
        next_state.blank_n = wdata[BLANK_BIT];
      end
      if (addr == FORMAT_CTRL_ADDR) begin
        next_state.static_drive = wdata[FORMAT_BIT];
        next_state.timer_mask = wdata[MASK_LSB +: MASK_W];
      end
    end

    // Register reads; data stand only in the following cycle
    next_state.rd_mem = rd && mem_hit && DISP_READABLE;
    next_state.reg_rdata = 4'h0;
    if (rd) begin
      if (addr == BLANK_CTRL_ADDR) begin
        // Upper bits read as zero
        next_state.reg_rdata[BLANK_BIT] = state.blank_n;
      end else if (addr == FORMAT_CTRL_ADDR) begin
        next_state.reg_rdata[FORMAT_BIT] = state.static_drive;
        next_state.reg_rdata[MASK_LSB +: MASK_W] = state.timer_mask;
      end
      // Page 2 window and unmapped addresses read as zero
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state.osc_acc <= 28'h0000000;
      state.tick_cnt <= 10'h000;
      state.com_idx <= 2'h0;
      state.phase <= 1'b0;
      state.blank_n <= BLANK_RESET;
      state.static_drive <= FORMAT_RESET;
      state.timer_mask <= MASK_RESET;
      state.rd_mem <= 1'b0;
      state.reg_rdata <= 4'h0;
      state.com_out <= 4'h0;
      state.seg_out <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata = state.rd_mem ? dm.rdata : state.reg_rdata;
  assign common_terminals = state.com_out;
  assign segment_terminals = state.seg_out;
  assign drive_phase = state.phase;
  assign drive_format_select = state.static_drive;
  assign display_blank_ctrl = state.blank_n;
  assign timer_int_mask = state.timer_mask;
endmodule : lcd_segment_drive_control

// [tb/lcd_drive_checker.sv]
// Purpose: Port assertions for the LCD segment drive control
// Assumes: One clock, reset asynchronous and active high
// Notes:   Bound to every instance; DC segment pairs come in by parameter
`timescale 1ns/10ps
module lcd_drive_checker
  import lcd_drive_pkg::*;
#(
  parameter logic [DC_PAIRS-1:0] DC_PAIR_MASK = '0 // Segment pairs as DC outputs
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [COM_COUNT-1:0] common_terminals,
  input wire logic [SEG_COUNT-1:0] segment_terminals,
  input wire logic drive_format_select,
  input wire logic display_blank_ctrl,
  input wire logic [MASK_W-1:0] timer_int_mask
);
  // ==========================================================
  // Clocking and decodes
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire logic blank_wr = wr && addr == BLANK_CTRL_ADDR; // Blank bit write
  wire logic fmt_wr = wr && addr == FORMAT_CTRL_ADDR; // Format write
  wire logic [SEG_COUNT-1:0] lcd_seg_mask; // Segments with LCD waveform, not DC
  logic live; // Outputs have left their reset values

  // DC pairs keep their first common bit while blanked
  for (genvar s = 0; s < SEG_COUNT; s++) begin : g_mask
    assign lcd_seg_mask[s] = !DC_PAIR_MASK[s / 2];
  end

  // Commons read zero until the first edge after reset release
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      live <= 1'b0;
    end else begin
      live <= 1'b1;
    end
  end

  // ==========================================================
  // Assertions
  chk_blank_write: assert property (
    blank_wr |=> display_blank_ctrl == $past(wdata[BLANK_BIT])) else $error("blank bit lost");
  chk_blank_hold: assert property (
    !blank_wr |=> $stable(display_blank_ctrl)) else $error("blank bit moved");
  chk_fmt_write: assert property (
    fmt_wr |=> {drive_format_select, timer_int_mask} == $past(wdata))
    else $error("format write lost");
  chk_fmt_hold: assert property (
    !fmt_wr |=> $stable({drive_format_select, timer_int_mask})) else $error("format moved");
  chk_blank_read: assert property (
    rd && addr == BLANK_CTRL_ADDR |=> rdata == {3'h0, display_blank_ctrl})
    else $error("blank readback wrong");
  chk_fmt_read: assert property (
    rd && addr == FORMAT_CTRL_ADDR |=> rdata == {drive_format_select, timer_int_mask})
    else $error("format readback wrong");
  chk_rdata_idle: assert property (
    !rd |=> rdata == 4'h0) else $error("read data without read");
  chk_blank_segs: assert property (
    !display_blank_ctrl [*2] |-> (segment_terminals & lcd_seg_mask) == '0)
    else $error("segment lit blanked");
  chk_com_shape: assert property (
    live |-> $onehot(common_terminals) || common_terminals == 4'hf) else $error("bad commons");

  // Main scenarios
  cov_blank: cover property (blank_wr ##1 !display_blank_ctrl);
  cov_static: cover property (drive_format_select [*3]);
  cov_mem_read: cover property (rd && addr == DISP_BASE_PAGE0);
endmodule : lcd_drive_checker

bind lcd_segment_drive_control lcd_drive_checker #(.DC_PAIR_MASK(DC_PAIR_MASK)) chk (
  .clock(clock), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .common_terminals(common_terminals), .segment_terminals(segment_terminals),
  .drive_format_select(drive_format_select), .display_blank_ctrl(display_blank_ctrl),
  .timer_int_mask(timer_int_mask));

// [tb/lcd_panel_model.sv]
// Purpose: Passive LCD glass seen through common and segment lines
// Assumes: Common line high means that common is driven
// Notes:   Keeps the image last shown under the first common
`timescale 1ns/10ps
module lcd_panel_model (
  input wire logic clock,
  input wire logic [3:0] common_terminals,
  input wire logic [47:0] segment_terminals,
  output logic [47:0] lit_com0
);
  // Glass latches segments while the first common is active
  always_ff @(posedge clock) begin
    if (common_terminals[0]) begin
      lit_com0 <= segment_terminals;
    end
  end
endmodule : lcd_panel_model

// [tb/lcd_segment_drive_control_bench.sv]
// Purpose: Self-checking bench for the LCD segment drive control
// Assumes: Page 0 memory, four commons, no DC pairs; second instance page 2, one DC pair
// Notes:   Reads are noted in a queue and checked by a monitor
`timescale 1ns/10ps
module lcd_segment_drive_control_bench;
  import lcd_drive_pkg::*;
  // ==========================================================
  // Signals
  logic clock = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [3:0] wdata = 4'h0;
  logic [3:0] rdata, common_terminals, exp_q[$], v;
  logic [47:0] segment_terminals, lit_com0, col0;
  logic drive_phase, drive_format_select, display_blank_ctrl;
  logic [2:0] timer_int_mask;
  logic [3:0] rdata2, common2, exp2_q[$]; // Second instance read data and notes
  logic [47:0] segs2; // Second instance segments
  logic [11:0] addr2; // Display window moved to page 2

  // Low addresses go to the page 2 window, control registers unchanged
  assign addr2 = (addr < 12'h100) ? addr + 12'h200 : addr;
  int fails = 0, checks_done = 0, cycles = 0;

  always #5 clock = ~clock; // 100 MHz

  lcd_segment_drive_control dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .common_terminals(common_terminals),
    .segment_terminals(segment_terminals), .drive_phase(drive_phase),
    .drive_format_select(drive_format_select), .display_blank_ctrl(display_blank_ctrl),
    .timer_int_mask(timer_int_mask));
  lcd_segment_drive_control #(.DUTY(2), .DISPLAY_PAGE(2), .DC_PAIR_MASK(24'h000001)) dut2 (
    .clock(clock), .rst(rst), .addr(addr2), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata2),
    .common_terminals(common2), .segment_terminals(segs2), .drive_phase(),
    .drive_format_select(), .display_blank_ctrl(), .timer_int_mask());
  lcd_panel_model panel (.clock(clock), .common_terminals(common_terminals),
    .segment_terminals(segment_terminals), .lit_com0(lit_com0));

  // ==========================================================
  // Tasks
  task check(input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task final_report;
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  task wr_reg(input logic [11:0] a, input logic [3:0] d);
    @(posedge clock);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [11:0] a, input logic [3:0] e);
    @(posedge clock);
    addr <= a; rd <= 1'b1;
    exp_q.push_back(e);
    // Page 2 memory is write-only and reads zero in the second instance
    exp2_q.push_back((a >= DISP_BASE_PAGE0 && a < DISP_BASE_PAGE0 + 12'(DISP_WORDS)) ? 4'h0 : e);
    @(posedge clock);
    rd <= 1'b0;
  endtask : rd_reg
  task settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle

  // ==========================================================
  // Monitor: read data stands in the cycle after the strobe
  always @(posedge clock) rd_q <= rd;
  always @(negedge clock) begin
    if (rd_q) check(rdata, exp_q.pop_front());
    if (rd_q) check(rdata2, exp2_q.pop_front());
  end
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      final_report();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'ha846));
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    #1;
    check(display_blank_ctrl, 1'b1);
    check(drive_format_select, 1'b0);
    rd_reg(BLANK_CTRL_ADDR, 4'h1);
    rd_reg(FORMAT_CTRL_ADDR, 4'h0);
    // Start-up fill of the whole display memory, each word read back right after its write
    for (int i = 0; i < DISP_WORDS; i++) begin
      v = 4'($urandom());
      col0[i] = v[0];
      wr_reg(DISP_BASE_PAGE0 + 12'(i), v);
      rd_reg(DISP_BASE_PAGE0 + 12'(i), v);
    end
    rd_reg(DISP_BASE_PAGE0 + 12'(DISP_WORDS), 4'h0);
    settle(3);
    check(common_terminals, 4'h1);
    check(segment_terminals, col0);
    check(lit_com0, col0);
    check(common2, 4'h1);
    check(segs2, col0);
    // Blank, then restore the same image
    wr_reg(BLANK_CTRL_ADDR, 4'h0);
    settle(3);
    check(segment_terminals, 48'h0);
    check(segs2, {46'h0, col0[1:0]});
    rd_reg(BLANK_CTRL_ADDR, 4'h0);
    wr_reg(BLANK_CTRL_ADDR, 4'hf);
    rd_reg(BLANK_CTRL_ADDR, 4'h1);
    settle(3);
    check(segment_terminals, col0);
    check(segs2, col0);
    // Static drive with random mask bits, then back to dynamic
    v = {1'b1, 3'($urandom())};
    wr_reg(FORMAT_CTRL_ADDR, v);
    rd_reg(FORMAT_CTRL_ADDR, v);
    settle(1);
    check(drive_format_select, 1'b1);
    check(timer_int_mask, v[2:0]);
    check(common_terminals, 4'hf);
    wr_reg(FORMAT_CTRL_ADDR, 4'h0);
    settle(1);
    check(drive_format_select, 1'b0);
    check(common_terminals, 4'h1);
    // Unmapped neighbour is ignored and reads zero
    wr_reg(12'h2d1, 4'h0);
    rd_reg(12'h2d1, 4'h0);
    settle(2);
    check(display_blank_ctrl, 1'b1);
    // First frame is far from over, so polarity has not turned
    check(drive_phase, 1'b0);
    final_report();
  end
endmodule : lcd_segment_drive_control_bench
